// >>> av_pattern_src.sv
// Purpose: Model of the unit under test that returns the picture and sound pattern.
// Assumes: go_in pulses with the start write; delays count cycles after it.
// Notes: Black picture and silence are shown until each delay runs out.
`timescale 1ns/1ps
module av_pattern_src import av_sync_pkg::*; #(
   parameter int AUD_W = 24
) (
   input wire logic clock_in,
   input wire logic rst_n_in,
   input wire logic go_in,
   input wire logic [15:0] vid_dly_in,
   input wire logic [15:0] aud_dly_in,
   input wire logic [COMP_W-1:0] act_red_in,
   input wire logic signed [AUD_W-1:0] amp_in,
   output logic pix_valid_out,
   output logic [COMP_W-1:0] red_out,
   output logic [COMP_W-1:0] green_out,
   output logic [COMP_W-1:0] blue_out,
   output logic aud_valid_out,
   output logic signed [AUD_W-1:0] sample_out
);
   logic run_r;
   logic [15:0] t_r;
   logic vid_on;
   logic aud_on;
   always_ff @(posedge clock_in) begin
      if (!rst_n_in) begin
         run_r <= 1'b0;
         t_r <= 16'h0;
      end else if (go_in) begin
         run_r <= 1'b1;
         t_r <= 16'h0;
      end else if (run_r && t_r != 16'hffff) begin
         t_r <= t_r + 16'h1;
      end
   end
   // Picture swaps idle for active colour after vid_dly_in; sound is switched on separately after aud_dly_in.
   assign vid_on = run_r && (t_r >= vid_dly_in);
   assign aud_on = run_r && (t_r >= aud_dly_in);
   assign pix_valid_out = 1'b1;
   assign aud_valid_out = 1'b1;
   assign red_out = vid_on ? act_red_in : 12'h000;
   assign green_out = vid_on ? 12'h400 : 12'h000;
   assign blue_out = vid_on ? 12'h200 : 12'h000;
   assign sample_out = aud_on ? amp_in : '0;
endmodule

// >>> av_sync_offset_meter.sv
// Purpose: Measures the time offset between a video colour trigger and an audio level trigger.
// Assumes: Pixel and sample inputs are synchronous to clock_in.
// Notes: Results are read, and events are read and cleared, over the register port.
`timescale 1ns/1ps
module av_sync_offset_meter import av_sync_pkg::*; #(
   parameter int AUD_W = 24,
   parameter int CNT_W = 32
) (
   input wire logic clock_in,
   input wire logic rst_n_in,
   input wire logic [ADDR_W-1:0] addr_in,
   input wire logic [REG_W-1:0] wr_data_in,
   input wire logic wr_in,
   input wire logic rd_in,
   output logic [REG_W-1:0] rd_data_out,
   input wire logic pix_valid_in,
   input wire logic [COMP_W-1:0] pix_red_in,
   input wire logic [COMP_W-1:0] pix_green_in,
   input wire logic [COMP_W-1:0] pix_blue_in,
   input wire logic aud_valid_in,
   input wire logic signed [AUD_W-1:0] aud_sample_in,
   output logic busy_out,
   output logic irq_out
);

   // Clears the low bits that a reduced colour depth does not carry.
   function automatic logic [COMP_W-1:0] depth_mask(input logic [COMP_W-1:0] v,
                                                    input logic [DEPTH_W-1:0] d);
      logic [COMP_W-1:0] m;
      m = (d == DEPTH_8) ? MASK_8 : ((d == DEPTH_10) ? MASK_10 : MASK_12);
      return v & m;
   endfunction

   // True when a component lies inclusively between its bounds.
   function automatic logic in_bounds(input logic [COMP_W-1:0] v, input logic [COMP_W-1:0] lo,
                                      input logic [COMP_W-1:0] hi);
      return (lo <= v) && (v <= hi);
   endfunction

   meas_state_t state_r, state_nxt;
   logic [CNT_W-1:0] cnt_r, cnt_nxt;
   logic [CNT_W-1:0] win_r, win_nxt;
   logic [CNT_W-1:0] on_r, on_nxt;
   logic [CNT_W-1:0] vid_time_r, vid_time_nxt;
   logic [CNT_W-1:0] aud_time_r, aud_time_nxt;
   logic [CNT_W-1:0] offset_r, offset_nxt;
   logic [DEPTH_W-1:0] depth_r, depth_nxt;
   logic [COMP_W-1:0] lo_r [3];
   logic [COMP_W-1:0] lo_nxt [3];
   logic [COMP_W-1:0] hi_r [3];
   logic [COMP_W-1:0] hi_nxt [3];
   logic [AUD_W-1:0] thr_r, thr_nxt;
   logic vid_seen_r, vid_seen_nxt;
   logic aud_seen_r, aud_seen_nxt;
   logic valid_r, valid_nxt;
   logic [INT_W-1:0] int_stat_r, int_stat_nxt;
   logic [INT_W-1:0] int_mask_r, int_mask_nxt;
   logic [REG_W-1:0] rd_data_nxt;
   logic irq_nxt;
   logic [COMP_W-1:0] pix_m [3];
   logic [AUD_W-1:0] aud_mag;
   logic vid_hit;
   logic aud_hit;
   logic start_req;
   logic evt_done;
   logic evt_timeout;
   logic evt_cfg;

   always_comb begin
      pix_m[IDX_RED] = depth_mask(pix_red_in, depth_r);
      pix_m[IDX_GREEN] = depth_mask(pix_green_in, depth_r);
      pix_m[IDX_BLUE] = depth_mask(pix_blue_in, depth_r);
      vid_hit = pix_valid_in;
      for (int i = 0; i < 3; i++) begin
         vid_hit = vid_hit && in_bounds(pix_m[i], lo_r[i], hi_r[i]);
      end
      // Level is compared by magnitude, so a negative swing triggers as well.
      aud_mag = aud_sample_in[AUD_W-1] ? AUD_W'(-aud_sample_in) : aud_sample_in;
      aud_hit = aud_valid_in && (aud_mag > thr_r);
   end

   always_comb begin
      state_nxt = state_r;
      cnt_nxt = cnt_r;
      win_nxt = win_r;
      on_nxt = on_r;
      vid_time_nxt = vid_time_r;
      aud_time_nxt = aud_time_r;
      offset_nxt = offset_r;
      depth_nxt = depth_r;
      lo_nxt = lo_r;
      hi_nxt = hi_r;
      thr_nxt = thr_r;
      vid_seen_nxt = vid_seen_r;
      aud_seen_nxt = aud_seen_r;
      valid_nxt = valid_r;
      int_mask_nxt = int_mask_r;
      evt_done = 1'b0;
      evt_timeout = 1'b0;
      evt_cfg = 1'b0;
      start_req = wr_in && (addr_in == OFS_CTRL) && wr_data_in[CTRL_START_BIT];
      if (wr_in) begin
         unique case (addr_in)
            OFS_CTRL: depth_nxt = wr_data_in[CTRL_DEPTH_LSB +: DEPTH_W];
            OFS_WIN_LEN: begin
               // A window shortened mid-run could leave the counter past its end.
               if (state_r == ST_IDLE) begin
                  win_nxt = wr_data_in[CNT_W-1:0];
               end
            end
            OFS_ON_TIME: on_nxt = wr_data_in[CNT_W-1:0];
            OFS_LO_RG: begin
               lo_nxt[IDX_RED] = depth_mask(wr_data_in[COMP_W-1:0], depth_r);
               lo_nxt[IDX_GREEN] = depth_mask(wr_data_in[GREEN_LSB +: COMP_W], depth_r);
            end
            OFS_LO_B: lo_nxt[IDX_BLUE] = depth_mask(wr_data_in[COMP_W-1:0], depth_r);
            OFS_HI_RG: begin
               hi_nxt[IDX_RED] = depth_mask(wr_data_in[COMP_W-1:0], depth_r);
               hi_nxt[IDX_GREEN] = depth_mask(wr_data_in[GREEN_LSB +: COMP_W], depth_r);
            end
            OFS_HI_B: hi_nxt[IDX_BLUE] = depth_mask(wr_data_in[COMP_W-1:0], depth_r);
            OFS_AUD_THR: thr_nxt = wr_data_in[AUD_W-1:0];
            OFS_INT_MASK: int_mask_nxt = wr_data_in[INT_W-1:0];
            default: ;
         endcase
      end
      unique case (state_r)
         ST_IDLE: begin
            if (start_req) begin
               if (win_r > on_r) begin
                  state_nxt = ST_MEAS;
                  cnt_nxt = '0;
                  vid_seen_nxt = 1'b0;
                  aud_seen_nxt = 1'b0;
                  valid_nxt = 1'b0;
               end else begin
                  evt_cfg = 1'b1;
               end
            end
         end
         ST_MEAS: begin
            cnt_nxt = cnt_r + 1'b1;
            if (vid_hit && !vid_seen_r) begin
               vid_seen_nxt = 1'b1;
               vid_time_nxt = cnt_r;
            end
            if (aud_hit && !aud_seen_r) begin
               aud_seen_nxt = 1'b1;
               aud_time_nxt = cnt_r;
            end
            if (vid_seen_nxt && aud_seen_nxt) begin
               offset_nxt = vid_time_nxt - aud_time_nxt;
               valid_nxt = 1'b1;
               evt_done = 1'b1;
               state_nxt = ST_IDLE;
            end else if (cnt_r >= win_r - 1'b1) begin
               evt_timeout = 1'b1;
               state_nxt = ST_IDLE;
            end
         end
      endcase
      // A new event wins over a write-one clear in the same cycle.
      int_stat_nxt = int_stat_r;
      if (wr_in && (addr_in == OFS_INT_STAT)) begin
         int_stat_nxt = int_stat_r & ~wr_data_in[INT_W-1:0];
      end
      int_stat_nxt = int_stat_nxt | {evt_cfg, evt_timeout, evt_done};
      irq_nxt = |(int_stat_nxt & int_mask_nxt);
      rd_data_nxt = '0;
      if (rd_in) begin
         unique case (addr_in)
            OFS_CTRL: rd_data_nxt[CTRL_DEPTH_LSB +: DEPTH_W] = depth_r;
            OFS_STATUS: begin
               rd_data_nxt[ST_BUSY_BIT] = (state_r == ST_MEAS);
               rd_data_nxt[ST_VALID_BIT] = valid_r;
               rd_data_nxt[ST_VID_BIT] = vid_seen_r;
               rd_data_nxt[ST_AUD_BIT] = aud_seen_r;
            end
            OFS_WIN_LEN: rd_data_nxt[CNT_W-1:0] = win_r;
            OFS_ON_TIME: rd_data_nxt[CNT_W-1:0] = on_r;
            OFS_LO_RG: rd_data_nxt = {4'h0, lo_r[IDX_GREEN], 4'h0, lo_r[IDX_RED]};
            OFS_LO_B: rd_data_nxt[COMP_W-1:0] = lo_r[IDX_BLUE];
            OFS_HI_RG: rd_data_nxt = {4'h0, hi_r[IDX_GREEN], 4'h0, hi_r[IDX_RED]};
            OFS_HI_B: rd_data_nxt[COMP_W-1:0] = hi_r[IDX_BLUE];
            OFS_AUD_THR: rd_data_nxt[AUD_W-1:0] = thr_r;
            OFS_OFFSET: rd_data_nxt[CNT_W-1:0] = offset_r;
            OFS_INT_STAT: rd_data_nxt[INT_W-1:0] = int_stat_r;
            OFS_INT_MASK: rd_data_nxt[INT_W-1:0] = int_mask_r;
            default: ;
         endcase
      end
   end

   always_ff @(posedge clock_in) begin
      if (!rst_n_in) begin
         state_r <= ST_IDLE;
         cnt_r <= '0;
         win_r <= RST_WIN_LEN[CNT_W-1:0];
         on_r <= RST_ON_TIME[CNT_W-1:0];
         vid_time_r <= '0;
         aud_time_r <= '0;
         offset_r <= '0;
         depth_r <= RST_DEPTH;
         lo_r <= '{default: RST_CLR_LO};
         hi_r <= '{default: RST_CLR_HI};
         thr_r <= '0;
         vid_seen_r <= 1'b0;
         aud_seen_r <= 1'b0;
         valid_r <= 1'b0;
         int_stat_r <= '0;
         int_mask_r <= '0;
         rd_data_out <= '0;
         busy_out <= 1'b0;
         irq_out <= 1'b0;
      end else begin
         state_r <= state_nxt;
         cnt_r <= cnt_nxt;
         win_r <= win_nxt;
         on_r <= on_nxt;
         vid_time_r <= vid_time_nxt;
         aud_time_r <= aud_time_nxt;
         offset_r <= offset_nxt;
         depth_r <= depth_nxt;
         lo_r <= lo_nxt;
         hi_r <= hi_nxt;
         thr_r <= thr_nxt;
         vid_seen_r <= vid_seen_nxt;
         aud_seen_r <= aud_seen_nxt;
         valid_r <= valid_nxt;
         int_stat_r <= int_stat_nxt;
         int_mask_r <= int_mask_nxt;
         rd_data_out <= rd_data_nxt;
         busy_out <= (state_nxt == ST_MEAS);
         irq_out <= irq_nxt;
      end
   end

   default clocking cb @(posedge clock_in); endclocking
   default disable iff (!rst_n_in);

   a_video_first_hit: assert property (
      (state_r == ST_MEAS) && vid_hit && !vid_seen_r
      |=> vid_seen_r && (vid_time_r == $past(cnt_r)))
      else $error("Video trigger not latched on first matching pixel.");
   a_colour_all_inside: assert property (
      vid_hit |-> pix_valid_in && (lo_r[IDX_RED] <= pix_m[IDX_RED])
      && (pix_m[IDX_RED] <= hi_r[IDX_RED]) && (lo_r[IDX_GREEN] <= pix_m[IDX_GREEN])
      && (pix_m[IDX_GREEN] <= hi_r[IDX_GREEN]) && (lo_r[IDX_BLUE] <= pix_m[IDX_BLUE])
      && (pix_m[IDX_BLUE] <= hi_r[IDX_BLUE]))
      else $error("Video trigger with a component outside its bounds.");
   a_depth_low_zero: assert property (
      (depth_r == DEPTH_8) |-> (pix_m[IDX_RED][3:0] == 4'h0) && (pix_m[IDX_BLUE][3:0] == 4'h0))
      else $error("Unused low colour bits not cleared.");
   a_audio_first_hit: assert property (
      (state_r == ST_MEAS) && aud_hit && !aud_seen_r
      |=> aud_seen_r && (aud_time_r == $past(cnt_r)))
      else $error("Audio trigger not latched on first exceeding sample.");
   a_offset_signed: assert property (
      $rose(valid_r) |-> (offset_r == vid_time_r - aud_time_r) && int_stat_r[INT_DONE_BIT])
      else $error("Offset not equal to video time minus audio time.");
   a_start_refused: assert property (
      (state_r == ST_IDLE) && start_req && !(win_r > on_r)
      |=> (state_r == ST_IDLE) && int_stat_r[INT_CFG_BIT] && !busy_out)
      else $error("Bad configuration did not refuse the start.");
   a_window_end: assert property (
      (state_r == ST_MEAS) && (cnt_r >= win_r - 1'b1) && !(vid_seen_nxt && aud_seen_nxt)
      |=> (state_r == ST_IDLE) && int_stat_r[INT_TIMEOUT_BIT] && !valid_r)
      else $error("Missing trigger at window end did not time out.");
   a_window_bound: assert property (
      (state_r == ST_MEAS) |-> (cnt_r < win_r))
      else $error("Observation ran past the window length.");
   a_count_clear: assert property (
      (state_r == ST_IDLE) && start_req && (win_r > on_r) ##1 (state_r == ST_MEAS)[*2]
      |-> (cnt_r == 1) && $past(cnt_r) == 0)
      else $error("Counter did not clear at start and then advance.");

   a_offset_negative: assert property (
      $rose(valid_r) && (vid_time_r < aud_time_r) |-> offset_r[CNT_W-1])
      else $error("Offset not negative although video triggered first.");
   a_idle_no_latch: assert property (
      (state_r == ST_IDLE) |=> $stable(vid_time_r) && $stable(aud_time_r))
      else $error("Trigger time latched outside the observation window.");
   a_count_advance: assert property (
      (state_r == ST_MEAS) |=> (cnt_r == $past(cnt_r) + 1'b1))
      else $error("Measurement counter did not advance by one.");
   a_depth_ten_zero: assert property (
      (depth_r == DEPTH_10)
      |-> (pix_m[IDX_RED][1:0] == 2'h0) && (pix_m[IDX_GREEN][1:0] == 2'h0))
      else $error("Unused low colour bits not cleared at ten-bit depth.");
   a_busy_window: assert property (
      busy_out == (state_r == ST_MEAS))
      else $error("Busy output does not follow the observation window.");
   a_start_accepted: assert property (
      (state_r == ST_IDLE) && start_req && (win_r > on_r) |=> (state_r == ST_MEAS) && busy_out)
      else $error("Valid configuration did not start a measurement.");

   // Cover points for finished, timed-out, refused and ten-bit runs.
   c_measure_done: cover property ((state_r == ST_MEAS) ##[1:1000] $rose(valid_r));
   c_timeout: cover property ($rose(int_stat_r[INT_TIMEOUT_BIT]));
   c_cfg_error: cover property ($rose(int_stat_r[INT_CFG_BIT]));
   c_negative_offset: cover property ($rose(valid_r) && offset_r[CNT_W-1]);
   c_ten_bit_hit: cover property ((state_r == ST_MEAS) && (depth_r == DEPTH_10) && vid_hit);
endmodule

// >>> av_sync_pkg.sv
// Purpose: Constants and types for the audio/video sync offset meter.
// Assumes: One clock, 32-bit register port with byte addresses.
// Notes: Times are counted in clock cycles.
package av_sync_pkg;
   localparam int COMP_W = 12;
   localparam int REG_W = 32;
   localparam int ADDR_W = 8;
   localparam int DEPTH_W = 2;
   localparam int INT_W = 3;
   localparam logic [ADDR_W-1:0] OFS_CTRL = 8'h00;
   localparam logic [ADDR_W-1:0] OFS_STATUS = 8'h04;
   localparam logic [ADDR_W-1:0] OFS_WIN_LEN = 8'h08;
   localparam logic [ADDR_W-1:0] OFS_ON_TIME = 8'h0c;
   localparam logic [ADDR_W-1:0] OFS_LO_RG = 8'h10;
   localparam logic [ADDR_W-1:0] OFS_LO_B = 8'h14;
   localparam logic [ADDR_W-1:0] OFS_HI_RG = 8'h18;
   localparam logic [ADDR_W-1:0] OFS_HI_B = 8'h1c;
   localparam logic [ADDR_W-1:0] OFS_AUD_THR = 8'h20;
   localparam logic [ADDR_W-1:0] OFS_OFFSET = 8'h24;
   localparam logic [ADDR_W-1:0] OFS_INT_STAT = 8'h28;
   localparam logic [ADDR_W-1:0] OFS_INT_MASK = 8'h2c;
   localparam int CTRL_START_BIT = 0;
   localparam int CTRL_DEPTH_LSB = 1;
   localparam int GREEN_LSB = 16;
   localparam int ST_BUSY_BIT = 0;
   localparam int ST_VALID_BIT = 1;
   localparam int ST_VID_BIT = 2;
   localparam int ST_AUD_BIT = 3;
   localparam int INT_DONE_BIT = 0;
   localparam int INT_TIMEOUT_BIT = 1;
   localparam int INT_CFG_BIT = 2;
   localparam int IDX_RED = 0;
   localparam int IDX_GREEN = 1;
   localparam int IDX_BLUE = 2;
   localparam logic [DEPTH_W-1:0] DEPTH_8 = 2'h0;
   localparam logic [DEPTH_W-1:0] DEPTH_10 = 2'h1;
   localparam logic [COMP_W-1:0] MASK_8 = 12'hff0;
   localparam logic [COMP_W-1:0] MASK_10 = 12'hffc;
   localparam logic [COMP_W-1:0] MASK_12 = 12'hfff;
   localparam logic [DEPTH_W-1:0] RST_DEPTH = 2'h2;
   localparam logic [REG_W-1:0] RST_WIN_LEN = 32'h0001_0000;
   localparam logic [REG_W-1:0] RST_ON_TIME = 32'h0000_8000;
   localparam logic [COMP_W-1:0] RST_CLR_LO = 12'h000;
   localparam logic [COMP_W-1:0] RST_CLR_HI = 12'hfff;
   typedef enum logic {ST_IDLE, ST_MEAS} meas_state_t;
endpackage

// >>> tb.sv
// Purpose: Self-checking bench for the sync offset meter.
// Assumes: The pattern model stands in for the unit under test.
// Notes: Ordinary cases are table rows; reset checks precede them and interrupt checks follow, by hand.
`timescale 1ns/1ps
module tb import av_sync_pkg::*; ;
   typedef struct packed {
      logic [1:0] dep;
      logic [11:0] red;
      logic [15:0] vd;
      logic [15:0] ad;
      logic [31:0] win;
      logic [31:0] on;
      logic [23:0] amp;
      logic [2:0] st;
      logic [3:0] sts;
   } row_t;
   row_t rows [12] = '{
      '{2'h2, 12'h800, 16'h3, 16'h7, 32'h28, 32'h14, 24'h000200, 3'h1, 4'he},
      '{2'h2, 12'h800, 16'h9, 16'h2, 32'h28, 32'h14, 24'h000200, 3'h1, 4'he},
      '{2'h2, 12'h700, 16'h5, 16'h5, 32'h28, 32'h14, 24'hfffe00, 3'h1, 4'he},
      '{2'h2, 12'h800, 16'h0, 16'h27, 32'h28, 32'h14, 24'h000200, 3'h1, 4'he},
      '{2'h2, 12'h800, 16'h0, 16'h28, 32'h28, 32'h14, 24'h000200, 3'h2, 4'h4},
      '{2'h2, 12'h800, 16'h1, 16'h1, 32'h28, 32'h14, 24'h000100, 3'h2, 4'h4},
      '{2'h2, 12'h801, 16'h1, 16'h1, 32'h28, 32'h14, 24'h000200, 3'h2, 4'h8},
      '{2'h0, 12'h80f, 16'h4, 16'h1, 32'h28, 32'h14, 24'h000200, 3'h1, 4'he},
      '{2'h2, 12'h80f, 16'h4, 16'h1, 32'h28, 32'h14, 24'h000200, 3'h2, 4'h8},
      '{2'h2, 12'h800, 16'h1, 16'h1, 32'h14, 32'h14, 24'h000200, 3'h4, 4'h8},
      '{2'h2, 12'h800, 16'h1, 16'h1, 32'h15, 32'h14, 24'h000200, 3'h1, 4'he},
      '{2'h1, 12'h803, 16'h6, 16'h2, 32'h28, 32'h14, 24'h000200, 3'h1, 4'he}};
   logic clock_in = 1'b0;
   logic rst_n_in = 1'b0;
   logic wr_in = 1'b0;
   logic rd_in = 1'b0;
   logic go = 1'b0;
   logic [ADDR_W-1:0] addr = '0;
   logic [REG_W-1:0] wdata = '0;
   logic [REG_W-1:0] rd_data;
   logic [15:0] vd = '0;
   logic [15:0] ad = '0;
   logic [COMP_W-1:0] red = '0;
   logic signed [23:0] amp = '0;
   logic [COMP_W-1:0] pr, pg, pb;
   logic pv, av, busy, irq;
   logic signed [23:0] smp;
   int failures = 0;
   int checks_done = 0;
   always #4 clock_in = ~clock_in;
   av_sync_offset_meter DUT (.clock_in(clock_in), .rst_n_in(rst_n_in), .addr_in(addr),
      .wr_data_in(wdata), .wr_in(wr_in), .rd_in(rd_in), .rd_data_out(rd_data),
      .pix_valid_in(pv), .pix_red_in(pr), .pix_green_in(pg), .pix_blue_in(pb),
      .aud_valid_in(av), .aud_sample_in(smp), .busy_out(busy), .irq_out(irq));
   av_pattern_src src (.clock_in(clock_in), .rst_n_in(rst_n_in), .go_in(go),
      .vid_dly_in(vd), .aud_dly_in(ad), .act_red_in(red), .amp_in(amp),
      .pix_valid_out(pv), .red_out(pr), .green_out(pg), .blue_out(pb),
      .aud_valid_out(av), .sample_out(smp));
   task automatic stop_test();
      $display("Counts: %0d checks, %0d failures", checks_done, failures);
      if (failures == 0 && checks_done > 0) begin
         $display("STATUS OK");
      end else begin
         $display("STATUS NOT OK");
      end
      $finish;
   endtask
   task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
      checks_done++;
      if (g !== e) begin
         failures++;
         $display("Error %s expected %h seen %h", nm, e, g);
      end
   endtask
   task automatic wr(input logic [ADDR_W-1:0] a, input logic [REG_W-1:0] d, input logic g);
      @(posedge clock_in);
      wr_in <= 1'b1;
      addr <= a;
      wdata <= d;
      go <= g;
      @(posedge clock_in);
      wr_in <= 1'b0;
      go <= 1'b0;
   endtask
   task automatic rd(input logic [ADDR_W-1:0] a, output logic [REG_W-1:0] d);
      @(posedge clock_in);
      rd_in <= 1'b1;
      addr <= a;
      @(posedge clock_in);
      rd_in <= 1'b0;
      #1 d = rd_data;
   endtask
   task automatic run(input row_t r);
      int n;
      wr(OFS_WIN_LEN, r.win, 1'b0);
      wr(OFS_ON_TIME, r.on, 1'b0);
      vd <= r.vd;
      ad <= r.ad;
      red <= r.red;
      amp <= r.amp;
      wr(OFS_CTRL, {29'h0, r.dep, 1'b1}, 1'b1);
      n = 0;
      #1;
      while (busy !== 1'b0 && n < 200) begin
         @(posedge clock_in);
         #1;
         n++;
      end
      if (n == 200) begin
         chk("busy wait", 32'h0, 32'h1);
         stop_test();
      end
   endtask
   initial begin
      logic [REG_W-1:0] d;
      repeat (10) @(posedge clock_in);
      rst_n_in <= 1'b1;
      #1;
      chk("busy", 32'h0, {31'h0, busy});
      chk("irq", 32'h0, {31'h0, irq});
      rd(OFS_WIN_LEN, d);
      chk("win_len", RST_WIN_LEN, d);
      rd(OFS_ON_TIME, d);
      chk("on_time", RST_ON_TIME, d);
      rd(OFS_HI_B, d);
      chk("hi_blue", {20'h0, RST_CLR_HI}, d);
      rd(OFS_INT_MASK, d);
      chk("int_mask", 32'h0, d);
      rd(8'h30, d);
      chk("unmapped", 32'h0, d);
      @(posedge clock_in);
      #1;
      chk("rd_data idle", 32'h0, rd_data);
      $display("test reset done");
      wr(OFS_LO_RG, 32'h0300_0700, 1'b0);
      wr(OFS_HI_RG, 32'h0500_0800, 1'b0);
      wr(OFS_LO_B, 32'h0000_0100, 1'b0);
      wr(OFS_HI_B, 32'h0000_0300, 1'b0);
      wr(OFS_AUD_THR, 32'h0000_0100, 1'b0);
      for (int i = 0; i < 12; i++) begin
         run(rows[i]);
         rd(OFS_INT_STAT, d);
         chk("int_stat", {29'h0, rows[i].st}, d);
         rd(OFS_STATUS, d);
         chk("status", {28'h0, rows[i].sts}, d);
         if (rows[i].st == 3'h1) begin
            rd(OFS_OFFSET, d);
            chk("offset", {16'h0, rows[i].vd} - {16'h0, rows[i].ad}, d);
         end
         wr(OFS_INT_STAT, 32'h7, 1'b0);
         $display("test row %0d done", i);
      end
      run(rows[1]);
      chk("irq masked", 32'h0, {31'h0, irq});
      wr(OFS_INT_MASK, 32'h1, 1'b0);
      @(posedge clock_in);
      #1;
      chk("irq raised", 32'h1, {31'h0, irq});
      wr(OFS_INT_STAT, 32'h1, 1'b0);
      @(posedge clock_in);
      #1;
      chk("irq cleared", 32'h0, {31'h0, irq});
      $display("test interrupt done");
      stop_test();
   end
endmodule
